// ===== rtl/rxpwr_pkg.sv
// Purpose: shared constants for the receiver power controller
// Assumes: 40 MHz clock, voltages in mV, currents in mA
// Notes:   packet headers and register offsets live here only
package rxpwr_pkg;
   // clock and link timing
   localparam int unsigned CLK_HZ       = 40_000_000;
   localparam int unsigned BIT_RATE_BPS = 2_000;     // bi-phase bit rate
   localparam int unsigned CE_FAST_MS   = 30;        // error period, above target
   localparam int unsigned CE_SLOW_MS   = 250;       // error period, steady
   localparam int unsigned HALF_CYC_D   = CLK_HZ / (2 * BIT_RATE_BPS);
   localparam int unsigned FAST_CYC_D   = (CLK_HZ / 1000) * CE_FAST_MS;
   localparam int unsigned SLOW_CYC_D   = (CLK_HZ / 1000) * CE_SLOW_MS;
   // rectifier targets, mV
   localparam logic [15:0] RAMP_MV   = 16'h1B58; // 7000, ramp floor
   localparam logic [15:0] TGT0_MV   = 16'h1BA8; // 7080, below 10 %
   localparam logic [15:0] TGT1_MV   = 16'h1888; // 6280, 10..20 %
   localparam logic [15:0] TGT2_MV   = 16'h159A; // 5530, 20..40 %
   localparam logic [15:0] TGT3_MV   = 16'h13F6; // 5110, above 40 %
   localparam logic [15:0] CONV_MV   = 16'h0064; // settle band
   localparam logic [15:0] OVP_DEF   = 16'h3A98; // overvoltage default
   localparam logic [15:0] TENTH_K   = 16'h199A; // 0.1 in Q16
   localparam logic [3:0]  RP_EVERY  = 4'h4;     // power report divider
   localparam logic [3:0]  OVP_LIMIT = 4'h8;     // fast packets before end
   // packet headers and end codes
   localparam logic [7:0] HDR_SS   = 8'h01;
   localparam logic [7:0] HDR_EPT  = 8'h02;
   localparam logic [7:0] HDR_CE   = 8'h03;
   localparam logic [7:0] HDR_RP   = 8'h04;
   localparam logic [7:0] HDR_CFG  = 8'h51;
   localparam logic [7:0] HDR_ID   = 8'h71;
   localparam logic [7:0] EPT_UNK  = 8'h00;
   localparam logic [7:0] EPT_DONE = 8'h01;
   localparam logic [7:0] EPT_FLT  = 8'h02;
   localparam logic [7:0] EPT_HOT  = 8'h03;
   localparam logic [7:0] EPT_OVV  = 8'h04;
   localparam logic [7:0] SS_VAL   = 8'hFF;      // arbitrary
   localparam logic [7:0] CFG_VAL  = 8'h0A;      // arbitrary
   localparam logic [7:0] ID_VAL   = 8'h5A;      // arbitrary
   // register map, byte offsets
   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_STAT   = 8'h04;
   localparam logic [7:0] A_MASK   = 8'h08;
   localparam logic [7:0] A_STATE  = 8'h0C;
   localparam logic [7:0] A_TGT    = 8'h10;
   localparam logic [7:0] A_OVP    = 8'h14;
   localparam logic [1:0] RESP_OK  = 2'b00;
   localparam logic [1:0] RESP_ERR = 2'b10;
   // status bits
   localparam int ST_B_CONTRACT = 0;
   localparam int ST_B_OVP      = 1;
   localparam int ST_B_EPT      = 2;
   localparam int ST_B_PKT      = 3;
   localparam int NSTAT         = 4;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_SS   = 3'b001,
      S_CFG  = 3'b010,
      S_ID   = 3'b011,
      S_RAMP = 3'b100,
      S_MAIN = 3'b101,
      S_END  = 3'b110
   } state_type;
endpackage : rxpwr_pkg

// ===== rtl/rx_power_ctrl.sv
// Purpose: receiver-side power link controller with packet sender
// Assumes: analog levels arrive as synchronous digital words
// Notes:   registers over AXI4-Lite, one interrupt level output
// Operation
// R1: transmitter pings before any packet
// R2: strength, configuration, identification packets first
// R3: shutdown at start-up sends end packet
// R4: after three packets, receiver directs operating point
// R5: raise rectifier above 7 V before output
// R6: main loop sends control error packets
// R7: target follows current band percentages
// R8: each pass checks end conditions, ends transfer
// R9: periodically report received power from sense
// R10: maximum from constant; limit is 1.2x
// R11: errors every 30 ms, then 250 ms; here 30 ms only while rectifier is above target plus settle band
// R12: overvoltage disables regulator, requests lower voltage
// R13: overvoltage enables both clamp switches
// R14: packets only receiver to transmitter, by load
// R15: differential bi-phase at 2 kbps
// R16: band boundaries computed once after reset
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rx_power_ctrl #(
   parameter int unsigned HALF_CYC = rxpwr_pkg::HALF_CYC_D,
   parameter int unsigned FAST_CYC = rxpwr_pkg::FAST_CYC_D,
   parameter int unsigned SLOW_CYC = rxpwr_pkg::SLOW_CYC_D
) (
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rstn,
   // axi4-lite write
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   // axi4-lite read
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   // link and measurements
   input  wire logic        i_ping,
   input  wire logic [15:0] i_rect_mv,
   input  wire logic [15:0] i_iout_ma,
   input  wire logic [15:0] i_imax_ma,
   input  wire logic [11:0] i_received_power_sense,
   // shutdown sources
   input  wire logic        i_mode_select_a,
   input  wire logic        i_mode_select_b,
   input  wire logic        i_adapter_present,
   input  wire logic        i_ctrl_high,
   input  wire logic        i_ctrl_low,
   input  wire logic        i_internal_fault,
   // outputs
   output logic             o_mod,
   output logic             o_ldo_en,
   output logic             o_clamp_cap_one_en,
   output logic             o_clamp_cap_two_en,
   output logic [15:0]      o_hardware_overcurrent_limit,
   output logic             o_irq
);
   import rxpwr_pkg::*;

   state_type   state_r;        // sequencer state
   logic [15:0] b10_r;          // 10 % boundary
   logic        bnd_ok_r;       // boundaries captured
   logic [15:0] tgt_r;          // present rectifier target
   logic        ldo_r;          // output regulator on
   logic        clamp_r;        // clamp switches on
   logic        fast_r;         // 30 ms pacing active
   logic [23:0] tmr_r;          // error packet timer
   logic [3:0]  rp_cnt_r;       // packets since last report
   logic        rp_due_r;       // power report pending
   logic [3:0]  ovp_cnt_r;      // fast packets spent in overvoltage
   logic        contract_r;     // power contract held
   logic [NSTAT-1:0] stat_r;    // sticky events
   logic [NSTAT-1:0] mask_r;    // interrupt enables
   logic        sw_end_r;       // software end request
   logic [15:0] ovp_thr_r;      // overvoltage threshold
   // packet sender
   logic        go;             // start a packet
   logic [7:0]  go_hdr;         // header for it
   logic [7:0]  go_dat;         // payload byte
   logic        busy_r;         // frame on the wire
   logic [43:0] frm_r;          // bits left, lsb first
   logic [5:0]  left_r;         // bit count left
   logic [15:0] hcnt_r;         // half-bit counter
   logic        half_r;         // second half of bit
   logic [7:0]  ept_code;       // reason if ending
   logic        ept_need;       // any end condition
   logic        ovp;            // above threshold now
   logic        near;           // at or below target plus settle band
   logic signed [16:0] diff;    // target minus rectifier
   logic [7:0]  ce_val;         // saturated error byte
   logic [NSTAT-1:0] ev;        // event pulses
   logic [23:0] period;         // active error period

   // start bit, 8 data lsb first, odd parity, stop
   function automatic logic [10:0] byte_bits(input logic [7:0] d);
      byte_bits = {1'b1, ~^d, d, 1'b0};
   endfunction : byte_bits

   assign ovp  = i_rect_mv > ovp_thr_r;
   assign near = (i_rect_mv <= tgt_r + CONV_MV);
   assign diff = $signed({1'b0, tgt_r}) - $signed({1'b0, i_rect_mv});
   assign period = fast_r ? 24'(FAST_CYC - 1) : 24'(SLOW_CYC - 1); // see R11

   // error byte, 16 mV per step, saturated
   always_comb begin
      if (diff > 17'sd2032)
         ce_val = 8'h7F;
      else if (diff < -17'sd2048)
         ce_val = 8'h80;
      else
         ce_val = diff[11:4];
   end

   // end conditions in priority order
   always_comb begin
      ept_need = 1'b1;
      if (i_internal_fault)                         // see R8
         ept_code = EPT_FLT;
      else if (i_ctrl_low)
         ept_code = EPT_HOT;
      else if (i_mode_select_a && i_mode_select_b)
         ept_code = EPT_DONE;
      else if (i_mode_select_a || i_adapter_present || i_ctrl_high)
         ept_code = EPT_UNK;
      else if (ovp_cnt_r == OVP_LIMIT)              // no convergence
         ept_code = EPT_OVV;
      else if (sw_end_r)
         ept_code = EPT_UNK;
      else begin
         ept_code = EPT_UNK;
         ept_need = 1'b0;
      end
   end

   // boundaries captured once, after reset release
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         b10_r    <= 16'h0000;
         bnd_ok_r <= 1'b0;
      end else if (!bnd_ok_r) begin
         b10_r    <= 16'((32'(i_imax_ma) * 32'(TENTH_K)) >> 16); // see R16
         bnd_ok_r <= 1'b1;
      end
   end

   // hardware limit: max plus a fifth of it
   always_ff @(posedge i_mclk) begin
      if (!i_rstn)
         o_hardware_overcurrent_limit <= 16'h0000;
      else
         o_hardware_overcurrent_limit <= i_imax_ma + (b10_r << 1); // see R10
   end

   // target from current band
   always_ff @(posedge i_mclk) begin
      if (!i_rstn)
         tgt_r <= TGT0_MV;
      else if (state_r != S_MAIN)
         tgt_r <= TGT0_MV;                          // see R5
      else if (i_iout_ma < b10_r)
         tgt_r <= TGT0_MV;                          // see R7
      else if (i_iout_ma < (b10_r << 1))
         tgt_r <= TGT1_MV;
      else if (i_iout_ma < (b10_r << 2))
         tgt_r <= TGT2_MV;
      else
         tgt_r <= TGT3_MV;
   end

   // sequencer: handshake, ramp, main loop
   always_comb begin
      go     = 1'b0;
      go_hdr = HDR_CE;
      go_dat = ce_val;
      if (!busy_r) begin
         case (state_r)
            S_IDLE: begin
               if (i_ping && ept_need) begin        // see R3
                  go     = 1'b1;
                  go_hdr = HDR_EPT;
                  go_dat = ept_code;
               end else if (i_ping) begin           // see R1
                  go     = 1'b1;
                  go_hdr = HDR_SS;                  // see R2
                  go_dat = SS_VAL;
               end
            end
            S_SS: begin
               go     = 1'b1;
               go_hdr = HDR_CFG;
               go_dat = CFG_VAL;
            end
            S_CFG: begin
               go     = 1'b1;
               go_hdr = HDR_ID;
               go_dat = ID_VAL;
            end
            S_RAMP, S_MAIN: begin
               if (tmr_r == 24'h000000) begin
                  go = 1'b1;
                  if (ept_need) begin               // see R8
                     go_hdr = HDR_EPT;
                     go_dat = ept_code;
                  end
               end else if (rp_due_r) begin         // see R9
                  go     = 1'b1;
                  go_hdr = HDR_RP;
                  go_dat = i_received_power_sense[11:4];
               end
            end
            default: ;
         endcase
      end
   end

   // state transitions follow issued packets
   always_ff @(posedge i_mclk) begin
      if (!i_rstn)
         state_r <= S_IDLE;
      else if (go && go_hdr == HDR_EPT)
         state_r <= S_END;
      else begin
         case (state_r)
            S_IDLE: if (go) state_r <= S_SS;
            S_SS:   if (go) state_r <= S_CFG;
            S_CFG:  if (go) state_r <= S_ID;
            S_ID:   if (!busy_r) state_r <= S_RAMP; // see R4
            S_RAMP: if (ldo_r) state_r <= S_MAIN;
            S_MAIN: ;
            S_END:  if (!i_ping && !busy_r) state_r <= S_IDLE;
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // contract held once identification went out
   always_ff @(posedge i_mclk) begin
      if (!i_rstn)
         contract_r <= 1'b0;
      else if (state_r == S_END || state_r == S_IDLE)
         contract_r <= 1'b0;
      else if (state_r == S_ID && !busy_r)
         contract_r <= 1'b1;                        // see R4
   end

   // error packet pacing
   always_ff @(posedge i_mclk) begin
      if (!i_rstn)
         tmr_r <= 24'h000000;
      else if (!contract_r)
         tmr_r <= 24'h000000;
      else if (go && go_hdr == HDR_CE)
         tmr_r <= period;                           // see R6
      else if (tmr_r != 24'h000000)
         tmr_r <= tmr_r - 24'h000001;
   end

   // fast pacing until target reached again
   always_ff @(posedge i_mclk) begin
      if (!i_rstn)
         fast_r <= 1'b0;
      else if (i_rect_mv > tgt_r + CONV_MV)
         fast_r <= 1'b1;                            // see R11
      else if (near)
         fast_r <= 1'b0;
   end

   // power reports every few error packets
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         rp_cnt_r <= 4'h0;
         rp_due_r <= 1'b0;
      end else if (go && go_hdr == HDR_RP) begin
         rp_due_r <= 1'b0;
      end else if (go && go_hdr == HDR_CE && state_r == S_MAIN) begin
         if (rp_cnt_r == RP_EVERY - 4'h1) begin
            rp_cnt_r <= 4'h0;
            rp_due_r <= 1'b1;                       // see R9
         end else
            rp_cnt_r <= rp_cnt_r + 4'h1;
      end
   end

   // regulator and clamp control; overvoltage wins
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         ldo_r   <= 1'b0;
         clamp_r <= 1'b0;
      end else if (!contract_r) begin
         ldo_r   <= 1'b0;
         clamp_r <= 1'b0;
      end else if (ovp) begin
         ldo_r   <= 1'b0;                           // see R12
         clamp_r <= 1'b1;                           // see R13
      end else if (clamp_r) begin
         if (near)
            clamp_r <= 1'b0;
      end else if (i_rect_mv > RAMP_MV) begin
         ldo_r <= 1'b1;                             // see R5
      end
   end

   // count fast packets stuck in overvoltage
   always_ff @(posedge i_mclk) begin
      if (!i_rstn)
         ovp_cnt_r <= 4'h0;
      else if (!clamp_r)
         ovp_cnt_r <= 4'h0;
      else if (go && go_hdr == HDR_CE && ovp_cnt_r != OVP_LIMIT)
         ovp_cnt_r <= ovp_cnt_r + 4'h1;
   end

   // bi-phase sender: edge each bit, mid edge for a one
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         busy_r <= 1'b0;
         frm_r  <= 44'h0;
         left_r <= 6'd0;
         hcnt_r <= 16'h0000;
         half_r <= 1'b0;
         o_mod  <= 1'b0;
      end else if (go) begin
         busy_r <= 1'b1;                            // see R14
         frm_r  <= {byte_bits(go_hdr ^ go_dat), byte_bits(go_dat),
                    byte_bits(go_hdr), 11'h7FF};
         left_r <= 6'd44;
         hcnt_r <= 16'(HALF_CYC - 1);
         half_r <= 1'b0;
         o_mod  <= ~o_mod;                          // see R15
      end else if (busy_r) begin
         if (hcnt_r != 16'h0000)
            hcnt_r <= hcnt_r - 16'h0001;
         else begin
            hcnt_r <= 16'(HALF_CYC - 1);
            half_r <= ~half_r;
            if (!half_r) begin
               if (frm_r[0])
                  o_mod <= ~o_mod;                  // see R15
            end else begin
               frm_r  <= frm_r >> 1;
               left_r <= left_r - 6'd1;
               if (left_r == 6'd1)
                  busy_r <= 1'b0;
               else
                  o_mod <= ~o_mod;
            end
         end
      end
   end

   // ---------------- register bus ----------------
   logic wr_ok;                 // both write channels present
   logic [31:0] rd_mux;         // decoded read word
   logic        rd_hit;         // mapped read address
   assign wr_ok     = i_awvalid && i_wvalid && !o_bvalid;
   assign o_awready = wr_ok;
   assign o_wready  = wr_ok;
   assign o_arready = !o_rvalid;
   assign ev = {busy_r && left_r == 6'd1 && half_r && hcnt_r == 16'h0000,
                go && go_hdr == HDR_EPT,
                ovp && !clamp_r && contract_r,
                state_r == S_ID && !busy_r};

   // write response; unmapped offsets answer with an error
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         o_bvalid <= 1'b0;
         o_bresp  <= RESP_OK;
      end else if (wr_ok) begin
         o_bvalid <= 1'b1;
         o_bresp  <= (i_awaddr == A_CTRL || i_awaddr == A_STAT ||
                      i_awaddr == A_MASK || i_awaddr == A_OVP)
                     ? RESP_OK : RESP_ERR;
      end else if (i_bready)
         o_bvalid <= 1'b0;
   end

   // writable registers; a new event beats a clear
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         stat_r    <= '0;
         mask_r    <= '0;
         sw_end_r  <= 1'b0;
         ovp_thr_r <= OVP_DEF;
      end else begin
         if (wr_ok && i_awaddr == A_STAT && i_wstrb[0])
            stat_r <= (stat_r & ~i_wdata[NSTAT-1:0]) | ev;
         else
            stat_r <= stat_r | ev;
         if (wr_ok && i_awaddr == A_MASK && i_wstrb[0])
            mask_r <= i_wdata[NSTAT-1:0];
         if (wr_ok && i_awaddr == A_CTRL && i_wstrb[0])
            sw_end_r <= i_wdata[0];
         if (wr_ok && i_awaddr == A_OVP && i_wstrb[0])
            ovp_thr_r[7:0] <= i_wdata[7:0];
         if (wr_ok && i_awaddr == A_OVP && i_wstrb[1])
            ovp_thr_r[15:8] <= i_wdata[15:8];
      end
   end

   // read decode
   always_comb begin
      rd_hit = 1'b1;
      case (i_araddr)
         A_CTRL:  rd_mux = {31'h0, sw_end_r};
         A_STAT:  rd_mux = {28'h0, stat_r};
         A_MASK:  rd_mux = {28'h0, mask_r};
         A_STATE: rd_mux = {24'h0, fast_r, clamp_r, ldo_r,
                            contract_r, busy_r, state_r};
         A_TGT:   rd_mux = {16'h0, tgt_r};
         A_OVP:   rd_mux = {16'h0, ovp_thr_r};
         default: begin
            rd_mux = 32'h0;
            rd_hit = 1'b0;
         end
      endcase
   end

   // read answer held until taken
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         o_rvalid <= 1'b0;
         o_rdata  <= 32'h0;
         o_rresp  <= RESP_OK;
      end else if (i_arvalid && o_arready) begin
         o_rvalid <= 1'b1;
         o_rdata  <= rd_mux;
         o_rresp  <= rd_hit ? RESP_OK : RESP_ERR;
      end else if (i_rready)
         o_rvalid <= 1'b0;
   end

   assign o_irq              = |(stat_r & mask_r);
   assign o_ldo_en           = ldo_r;
   assign o_clamp_cap_one_en = clamp_r;
   assign o_clamp_cap_two_en = clamp_r;

   // ---------------- checks ----------------
   sequence s_ss_go;
      go && go_hdr == HDR_SS;
   endsequence
   sequence s_cfg_go;
      go && go_hdr == HDR_CFG;
   endsequence

   // frame length scales with the half-bit count, so no fixed delay range
   property p_hs_order;
      @(posedge i_mclk) disable iff (!i_rstn)
      s_ss_go |=> state_r == S_SS && busy_r;
   endproperty
   a_hs_order: assert property (p_hs_order) // see R2
      else $error("strength packet did not start the handshake");

   property p_cfg_next;
      @(posedge i_mclk) disable iff (!i_rstn)
      state_r == S_SS && !busy_r |-> s_cfg_go;
   endproperty
   a_cfg_next: assert property (p_cfg_next) // see R2
      else $error("config packet did not follow strength packet");

   property p_first_pkt;
      @(posedge i_mclk) disable iff (!i_rstn)
      go && state_r == S_IDLE |-> go_hdr == HDR_SS || go_hdr == HDR_EPT;
   endproperty
   a_first_pkt: assert property (p_first_pkt) // see R3
      else $error("wrong first packet after ping");

   property p_ce_contract;
      @(posedge i_mclk) disable iff (!i_rstn)
      go && go_hdr == HDR_CE |-> contract_r;
   endproperty
   a_ce_contract: assert property (p_ce_contract) // see R4
      else $error("error packet sent without contract");

   property p_ldo_ramp;
      @(posedge i_mclk) disable iff (!i_rstn)
      $rose(ldo_r) |-> $past(i_rect_mv) > RAMP_MV;
   endproperty
   a_ldo_ramp: assert property (p_ldo_ramp) // see R5
      else $error("regulator enabled below ramp level");

   property p_band;
      @(posedge i_mclk) disable iff (!i_rstn)
      state_r == S_MAIN && i_iout_ma >= (b10_r << 2) |=> tgt_r == TGT3_MV;
   endproperty
   a_band: assert property (p_band) // see R7
      else $error("high band target wrong");

   property p_ept_end;
      @(posedge i_mclk) disable iff (!i_rstn)
      go && go_hdr == HDR_EPT |=> state_r == S_END && busy_r;
   endproperty
   a_ept_end: assert property (p_ept_end) // see R8
      else $error("end packet did not end transfer");

   property p_ovp_react;
      @(posedge i_mclk) disable iff (!i_rstn)
      ovp && contract_r |=> !ldo_r && clamp_r;
   endproperty
   a_ovp_react: assert property (p_ovp_react) // see R12
      else $error("overvoltage not handled");

   property p_clamp_pair;
      @(posedge i_mclk) disable iff (!i_rstn)
      o_clamp_cap_one_en == o_clamp_cap_two_en && (clamp_r -> !ldo_r);
   endproperty
   a_clamp_pair: assert property (p_clamp_pair) // see R13
      else $error("clamp switches disagree");

   property p_fast_tmr;
      @(posedge i_mclk) disable iff (!i_rstn)
      go && go_hdr == HDR_CE && fast_r |=> tmr_r == 24'(FAST_CYC - 1);
   endproperty
   a_fast_tmr: assert property (p_fast_tmr) // see R11
      else $error("fast error period wrong");
endmodule : rx_power_ctrl
`default_nettype wire

// ===== sim/tx_pad_model.sv
// Purpose: pad-side listener that decodes load-modulated frames
// Assumes: bi-phase bits, half-bit length set by HALF
// Notes:   keeps only the header byte of each frame
`timescale 1ns/1ps
`default_nettype none
module tx_pad_model #(
   parameter int HALF = 4
) (
   // clock and link
   input  wire logic i_mclk,
   input  wire logic i_mod
);
   logic [43:0] bits_r;   // decoded frame, first bit at 0
   logic        prev_r;   // line level one cycle ago
   logic        a_r;      // level in first half of a bit
   int          cnt_r;    // cycle count in frame, -1 idle
   logic [7:0]  hdrs[$];  // headers in order of arrival
   initial begin
      cnt_r = -1;
      prev_r = 1'b0;
   end
   // listen only, never answer: the link is one way
   // sample mid-half so edge jitter of one cycle is harmless
   always @(posedge i_mclk) begin
      prev_r <= i_mod;
      if (cnt_r < 0) begin
         if ((i_mod ^ prev_r) === 1'b1) cnt_r <= 2;
      end else begin
         cnt_r <= cnt_r + 1;
         if (cnt_r % HALF == HALF / 2) begin
            if ((cnt_r / HALF) % 2 == 0) a_r <= i_mod;
            // mid-bit toggle marks a one
            else bits_r[cnt_r / HALF / 2] <= a_r ^ i_mod;
            if (cnt_r / HALF == 87) begin
               hdrs.push_back(bits_r[19:12]);
               cnt_r <= -1;
            end
         end
      end
   end
endmodule : tx_pad_model
`default_nettype wire

// ===== sim/wireless_rx_power_controller_tb.sv
// Purpose: self-checking bench for the receiver power controller
// Assumes: shortened half-bit and pacing counts
// Notes:   headers come from the pad model's decoder
`timescale 1ns/1ps
`default_nettype none
module wireless_rx_power_controller_tb;
   import rxpwr_pkg::*;
   logic        clk, rstn, awv, wv, bry, arv, rry, ping; // bench side
   logic [7:0]  awa, ara;          // bus addresses
   logic [31:0] wd, rd;            // bus data
   logic [15:0] rect, iout, imax, lim; // analog words
   logic [5:0]  sd;                // shutdown sources
   logic [3:0]  ws;                // write strobes
   logic [11:0] pws;               // power sense level
   logic        awr, wr, bv, arr, rv, mod, ldo, c1, c2, irq; // outputs
   logic [1:0]  br, rr;            // responses
   int          num_errors, n_compared, i, n; // tallies
   // fast period above one frame, so reports still find a free slot
   rx_power_ctrl #(.HALF_CYC(4), .FAST_CYC(500), .SLOW_CYC(800)) dut_u (
      .i_mclk(clk), .i_rstn(rstn), .i_awaddr(awa), .i_awvalid(awv),
      .o_awready(awr), .i_wdata(wd), .i_wstrb(ws), .i_wvalid(wv),
      .o_wready(wr), .o_bresp(br), .o_bvalid(bv), .i_bready(bry),
      .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rd),
      .o_rresp(rr), .o_rvalid(rv), .i_rready(rry), .i_ping(ping),
      .i_rect_mv(rect), .i_iout_ma(iout), .i_imax_ma(imax),
      .i_received_power_sense(pws), .i_mode_select_a(sd[0]),
      .i_mode_select_b(sd[1]), .i_adapter_present(sd[2]),
      .i_ctrl_high(sd[3]), .i_ctrl_low(sd[4]), .i_internal_fault(sd[5]),
      .o_mod(mod), .o_ldo_en(ldo), .o_clamp_cap_one_en(c1),
      .o_clamp_cap_two_en(c2), .o_hardware_overcurrent_limit(lim),
      .o_irq(irq));
   tx_pad_model #(.HALF(4)) tx_u (.i_mclk(clk), .i_mod(mod));
   // one tenth of the maximum, truncated like the hardware
   function automatic int tenth(input logic [15:0] m);
      return (int'(m) * 6554) >> 16;
   endfunction : tenth
   // band target; an exact boundary belongs to the upper band
   function automatic logic [15:0] tgt(input int c, input int t);
      if (c < t) return TGT0_MV;
      if (c < 2 * t) return TGT1_MV;
      if (c < 4 * t) return TGT2_MV;
      return TGT3_MV;
   endfunction : tgt
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // write: hold both channels until taken, then await response
   task automatic wreg(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] e);
      awa <= a; wd <= d; awv <= 1; wv <= 1;
      do @(posedge clk); while (!(awr && wr));
      awv <= 0; wv <= 0; bry <= 1;
      do @(posedge clk); while (!bv);
      bry <= 0;
      chk(32'(br), 32'(e));
   endtask : wreg
   task automatic rreg(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er);
      ara <= a; arv <= 1;
      do @(posedge clk); while (!arr);
      arv <= 0; rry <= 1;
      do @(posedge clk); while (!rv);
      rry <= 0;
      chk(rd, e);
      chk(32'(rr), 32'(er));
   endtask : rreg
   // wait for header number k and compare it
   task automatic hdr(input int k, input logic [7:0] e);
      while (tx_u.hdrs.size() <= k) @(posedge clk);
      chk(32'(tx_u.hdrs[k]), 32'(e));
   endtask : hdr
   task automatic summarize();
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize
   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   // hang guard, well above the longest expected run
   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      summarize();
   end
   initial begin
      {rstn, awv, wv, bry, arv, rry, ping, sd} = '0;
      {awa, ara, wd, rect, iout} = '0;
      ws = 4'hF;
      num_errors = 0;
      n_compared = 0;
      void'($urandom(64));
      imax = 16'(500 + $urandom % 1000);
      pws = 12'($urandom);
      repeat (3) @(posedge clk);
      rstn <= 1;
      @(posedge clk);
      rreg(A_OVP, 32'd15000, RESP_OK);
      ws <= 4'h1;
      wreg(A_OVP, 32'hFFFF_0012, RESP_OK);
      ws <= 4'hF;
      rreg(A_OVP, {16'h0, OVP_DEF[15:8], 8'h12}, RESP_OK);
      rreg(8'h18, 32'h0, RESP_ERR);
      wreg(A_TGT, 32'h1, RESP_ERR);
      wreg(A_MASK, 32'h1, RESP_OK);
      chk(32'(lim), 32'(int'(imax) + 2 * tenth(imax)));
      $display("registers done");
      ping <= 1;
      hdr(0, HDR_SS);
      hdr(1, HDR_CFG);
      hdr(2, HDR_ID);
      hdr(3, HDR_CE);
      chk(32'({ldo, irq}), 32'h1);
      rect <= 16'd7100;
      while (!ldo) @(posedge clk);
      wreg(A_STAT, 32'hF, RESP_OK);
      chk(32'(irq), 32'h0);
      $display("handshake done");
      // the three band edges and eight tenths, then random currents
      for (i = 0; i < 8; i++) begin
         iout <= 16'(i < 4 ? tenth(imax) << i : $urandom % (5 * imax));
         n = tx_u.hdrs.size();
         while (tx_u.hdrs.size() < n + 2) @(posedge clk);
         rreg(A_TGT, 32'(tgt(iout, tenth(imax))), RESP_OK);
      end
      n = 0;
      foreach (tx_u.hdrs[j]) n += int'(tx_u.hdrs[j] == HDR_RP);
      chk(32'(n > 0), 32'h1);
      $display("bands done");
      rect <= 16'd16000;
      repeat (3) @(posedge clk);
      chk(32'({ldo, c1, c2}), 32'h3);
      $display("overvoltage done");
      summarize();
   end
endmodule : wireless_rx_power_controller_tb
`default_nettype wire
